// *** design/scd_defs.svh ***
/*
 signaling change detector: offsets-free constants, field positions,
 reset values and timing figures.
 assumes: included once per compile unit through its guard.
*/
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH
`define SCD_SIG_W 7
`define SCD_TMR_W 5
`define SCD_CLK_NS 10
`define SCD_T3_NS 3000000
`define SCD_T10_NS 10000000
`define SCD_IGN_ALL 7'h7F
`define SCD_ERR_SRC_OVF 0
`define SCD_MODE_FIXED 1'b0
`endif

// *** design/scd_pkg.sv ***
/*
 signaling change detector: shared types.
 assumes: scd_defs.svh gives the field widths.
*/
`include "scd_defs.svh"
package scd_pkg;
    // per-slot configuration word
    typedef struct packed {
        logic prog;
        logic [`SCD_SIG_W-1:0] ign;
        logic [`SCD_TMR_W-1:0] t_fall;
        logic [`SCD_TMR_W-1:0] t_rise;
    } scd_cfg_t;
    // per-slot tracking word
    typedef struct packed {
        logic [`SCD_SIG_W-1:0] raw;
        logic [`SCD_SIG_W-1:0] vld;
        logic [`SCD_SIG_W-1:0] cand;
        logic [`SCD_TMR_W-1:0] cnt;
        logic e3;
        logic e10;
    } scd_st_t;
endpackage

// *** design/scd_top.sv ***
/*
 signaling change detector top: per-slot hit timing, report queue,
 service request, error and summary interrupt logic.
 assumes: one slot presented per SLOT_VALID_I pulse, software ports
 driven synchronously to CLK_I.
*/
// Function
// R01: validate A-G changes on every slot
// R02: looped slots monitored from source data
// R03: per-slot fixed/programmable select, fixed 3 ms
// R04: programmable interval 10 to 310 ms
// R05: separate falling and rising intervals
// R06: one control bit mutes a link
// R07: muted links keep validating state
// R08: per-slot mask ignores any bit set
// R09: reports queued and read in order
// R10: raw signaling bits readable per slot
// R11: validated state readable per slot
// R12: software forces a report any mode
// R13: reset sets all slots to ignore
// R14: service bit set while queue nonempty
// R15: masked service equals request AND mask
// R16: service bits active high
// R17: summary has error bits, service bit
// R18: interrupt on any unmasked summary bit
// R19: error bits set regardless of mask
// R20: error mask blocks interrupt contribution
// R21: error reg readable, cleared writing zero
// R22: atomic read-modify-write of control memory
// R23: full queue keeps entries, flags overflow
// R24: 10 ms ticks, 5-bit count 1..31
`timescale 1ns/1ps
`include "scd_defs.svh"
module scd_top
    import scd_pkg::*;
#(
    parameter int SLOT_W = 8,
    parameter int LINK_W = 2,
    parameter int FIFO_AW = 4,
    parameter int NPACK = 4,
    parameter int ERR_SRC_W = 8,
    parameter int T3_CYC = `SCD_T3_NS / `SCD_CLK_NS,
    parameter int T10_CYC = `SCD_T10_NS / `SCD_CLK_NS
)(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // incoming slot stream
    input wire logic SLOT_VALID_I,
    input wire logic [SLOT_W-1:0] SLOT_NUM_I,
    input wire logic [LINK_W-1:0] SLOT_LINK_I,
    input wire logic SLOT_LOOPED_I,
    input wire logic [`SCD_SIG_W-1:0] RX_SIG_I,
    input wire logic [`SCD_SIG_W-1:0] SRC_SIG_I,
    // link reporting mute
    input wire logic [(1<<LINK_W)-1:0] LINK_MUTE_I,
    // configuration read-modify-write
    input wire logic CFG_WE_I,
    input wire logic [SLOT_W-1:0] CFG_SLOT_I,
    input wire scd_cfg_t CFG_SET_I,
    input wire scd_cfg_t CFG_CLR_I,
    // slot readback
    input wire logic [SLOT_W-1:0] RD_SLOT_I,
    output logic [`SCD_SIG_W-1:0] RD_RAW_O,
    output logic [`SCD_SIG_W-1:0] RD_VLD_O,
    output scd_cfg_t RD_CFG_O,
    // forced report
    input wire logic FORCE_I,
    input wire logic [SLOT_W-1:0] FORCE_SLOT_I,
    output logic FORCE_BUSY_O,
    // report queue
    input wire logic FIFO_POP_I,
    output logic FIFO_EMPTY_O,
    output logic FIFO_FORCED_O,
    output logic [SLOT_W-1:0] FIFO_SLOT_O,
    output logic [`SCD_SIG_W-1:0] FIFO_SIG_O,
    // service request
    input wire logic [NPACK-1:1] PACK_PEND_I,
    input wire logic [NPACK-1:0] SR_MASK_I,
    output logic [NPACK-1:0] SR_O,
    output logic [NPACK-1:0] MSR_O,
    // errors
    input wire logic [ERR_SRC_W-1:1] ERR_I,
    input wire logic ERR_SRC_WE_I,
    input wire logic [ERR_SRC_W-1:0] ERR_SRC_WDATA_I,
    input wire logic [ERR_SRC_W-1:0] ERR_MASK_I,
    output logic [ERR_SRC_W-1:0] ERR_SRC_O,
    // summary interrupt
    input wire logic [NPACK-1:1] PACK_ERR_I,
    input wire logic [NPACK:0] ISR_MASK_I,
    output logic [NPACK:0] ISR_O,
    output logic IRQ_O
);
    localparam int NSLOT = 1 << SLOT_W;
    localparam int DEPTH = 1 << FIFO_AW;
    localparam int RW = 1 + SLOT_W + `SCD_SIG_W;

    scd_cfg_t cfg_mem [NSLOT];
    scd_st_t st_mem [NSLOT];
    logic [RW-1:0] fifo_mem [DEPTH];
    logic [FIFO_AW-1:0] wp_r, rp_r;
    logic [FIFO_AW:0] cnt_r;
    logic [19:0] c3_r, c10_r;
    logic e3_r, e10_r;
    logic fpend_r;
    logic [SLOT_W-1:0] fslot_r;
    logic [ERR_SRC_W-1:0] err_src_r;

    // timing epochs
    wire t3_end = c3_r == 20'(T3_CYC - 1);
    wire t10_end = c10_r == 20'(T10_CYC - 1);

    // slot evaluation
    wire scd_st_t st = st_mem[SLOT_NUM_I];
    wire scd_cfg_t cf = cfg_mem[SLOT_NUM_I];
    // R02: source not loop copy
    wire [`SCD_SIG_W-1:0] src = SLOT_LOOPED_I ? SRC_SIG_I : RX_SIG_I;
    wire tk3 = st.e3 != e3_r;
    wire tk10 = st.e10 != e10_r;
    // R08: masked bits never count
    wire [`SCD_SIG_W-1:0] diff = (src ^ st.vld) & ~cf.ign;
    wire stable = src == st.cand;
    // R05: falling uses on-hook timer
    wire falling = |(st.vld & ~src & ~cf.ign);
    wire [`SCD_TMR_W-1:0] lim_raw = falling ? cf.t_fall : cf.t_rise;
    // R24: zero treated as one tick
    wire [`SCD_TMR_W-1:0] lim = (lim_raw == '0) ? 5'h1 : lim_raw;
    wire [`SCD_TMR_W-1:0] cnt_inc = st.cnt + 5'h1;
    // R03: fixed needs two agreeing 3 ms samples
    wire acc_fix = tk3 && stable && (diff != '0);
    // R04: programmable in 10 ms ticks
    wire acc_prg = tk10 && stable && (diff != '0) && (cnt_inc >= lim);
    // R01: accept per selected method
    wire acc = (cf.prog == `SCD_MODE_FIXED) ? acc_fix : acc_prg;
    wire [`SCD_SIG_W-1:0] vld_nxt = acc ? src :
        ((st.vld & ~cf.ign) | (src & cf.ign));
    scd_st_t st_nxt;
    always_comb
    begin
        st_nxt = st;
        st_nxt.raw = src;
        st_nxt.vld = vld_nxt;
        st_nxt.e3 = e3_r;
        st_nxt.e10 = e10_r;
        if (cf.prog == `SCD_MODE_FIXED)
        begin
            if (tk3)
                st_nxt.cand = src;
            st_nxt.cnt = '0;
        end
        else if (!stable || diff == '0 || acc)
        begin
            st_nxt.cand = src;
            st_nxt.cnt = '0;
        end
        else if (tk10)
            st_nxt.cnt = cnt_inc;
    end

    // queue control
    wire full = cnt_r == (FIFO_AW+1)'(DEPTH);
    wire empty = cnt_r == '0;
    // R06: mute stops reporting only
    wire hw_push = SLOT_VALID_I && acc && !LINK_MUTE_I[SLOT_LINK_I];
    // R12: forced report queued when free
    wire f_push = fpend_r && !hw_push;
    wire push = hw_push || f_push;
    wire pop = FIFO_POP_I && !empty;
    // R23: drop new report when full
    wire wr = push && !full;
    wire [RW-1:0] rep = hw_push ? {1'b0, SLOT_NUM_I, vld_nxt} :
        {1'b1, fslot_r, st_mem[fslot_r].vld};
    wire [FIFO_AW:0] cnt_nxt = cnt_r + (FIFO_AW+1)'(wr) -
        (FIFO_AW+1)'(pop);

    // error sources
    wire [ERR_SRC_W-1:0] err_set = {ERR_I, push && full};

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            c3_r <= '0;
            c10_r <= '0;
            e3_r <= 1'b0;
            e10_r <= 1'b0;
            RD_RAW_O <= '0;
            RD_VLD_O <= '0;
            RD_CFG_O <= '0;
        end
        else
        begin
            c3_r <= t3_end ? '0 : c3_r + 20'h1;
            c10_r <= t10_end ? '0 : c10_r + 20'h1;
            e3_r <= e3_r ^ t3_end;
            e10_r <= e10_r ^ t10_end;
            // R10 R11: raw and valid readback
            RD_RAW_O <= st_mem[RD_SLOT_I].raw;
            RD_VLD_O <= st_mem[RD_SLOT_I].vld;
            RD_CFG_O <= cfg_mem[RD_SLOT_I];
        end
    end

    // R13: every slot starts ignored
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            for (int i = 0; i < NSLOT; i++)
            begin
                cfg_mem[i] <= '{prog: 1'b0, ign: `SCD_IGN_ALL,
                    t_fall: '0, t_rise: '0};
                st_mem[i] <= '0;
            end
        end
        else
        begin
            // R22: set/clear applied in one cycle
            if (CFG_WE_I)
                cfg_mem[CFG_SLOT_I] <= (cfg_mem[CFG_SLOT_I] & ~CFG_CLR_I)
                    | CFG_SET_I;
            // R07: state written even when muted
            if (SLOT_VALID_I)
                st_mem[SLOT_NUM_I] <= st_nxt;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            fpend_r <= 1'b0;
            fslot_r <= '0;
        end
        else
        begin
            // R09: write at tail, read at head
            if (wr)
                fifo_mem[wp_r] <= rep;
            wp_r <= wp_r + FIFO_AW'(wr);
            rp_r <= rp_r + FIFO_AW'(pop);
            cnt_r <= cnt_nxt;
            if (f_push)
                fpend_r <= 1'b0;
            else if (FORCE_I && !fpend_r)
            begin
                fpend_r <= 1'b1;
                fslot_r <= FORCE_SLOT_I;
            end
        end
    end

    // R19 R21: event set wins, write-only change
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            err_src_r <= '0;
        else
            err_src_r <= (ERR_SRC_WE_I ? ERR_SRC_WDATA_I : err_src_r) |
                err_set;
    end

    // head entry is held in flops; empty shows zeros
    wire [RW-1:0] head = empty ? '0 : fifo_mem[rp_r];
    assign FIFO_EMPTY_O = empty;
    assign FIFO_FORCED_O = head[RW-1];
    assign FIFO_SLOT_O = head[RW-2 -: SLOT_W];
    assign FIFO_SIG_O = head[`SCD_SIG_W-1:0];
    assign FORCE_BUSY_O = fpend_r;
    assign ERR_SRC_O = err_src_r;

    // R14 R16: own queue bit, active high
    assign SR_O = {PACK_PEND_I, !empty};
    // R15: request AND mask
    assign MSR_O = SR_O & SR_MASK_I;
    // R20: masked errors do not summarise
    wire own_err = |(err_src_r & ~ERR_MASK_I);
    // R17: pack error bits, own error bit plus service bit
    assign ISR_O = {PACK_ERR_I, own_err, |MSR_O};
    // R18: any unmasked summary bit
    assign IRQ_O = |(ISR_O & ~ISR_MASK_I);

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    property p_mute;
        SLOT_VALID_I && LINK_MUTE_I[SLOT_LINK_I] && !fpend_r && !FIFO_POP_I
            |=> cnt_r == $past(cnt_r);
    endproperty
    a_mute: assert property (p_mute) // R06
        else $error("muted link pushed a report");
    property p_sr;
        SR_O[0] == (cnt_r != '0);
    endproperty
    a_sr: assert property (p_sr) // R14
        else $error("service bit disagrees with queue");
    property p_msr;
        MSR_O == (SR_O & SR_MASK_I);
    endproperty
    a_msr: assert property (p_msr) // R15
        else $error("masked service mismatch");
    property p_isr;
        ISR_O[0] == |MSR_O && ISR_O[1] == |(ERR_SRC_O & ~ERR_MASK_I);
    endproperty
    a_isr: assert property (p_isr) // R17
        else $error("summary source mismatch");
    property p_irq;
        IRQ_O == |(ISR_O & ~ISR_MASK_I);
    endproperty
    a_irq: assert property (p_irq) // R18
        else $error("interrupt lead mismatch");
    property p_err;
        err_set != '0 |=> (ERR_SRC_O & $past(err_set)) == $past(err_set);
    endproperty
    a_err: assert property (p_err) // R19
        else $error("error event lost");
    property p_hold;
        !ERR_SRC_WE_I && err_set == '0 |=> $stable(ERR_SRC_O);
    endproperty
    a_hold: assert property (p_hold) // R21
        else $error("error register changed without write");
    sequence s_ovf;
        push && full && !pop;
    endsequence
    property p_ovf;
        s_ovf |=> ERR_SRC_O[`SCD_ERR_SRC_OVF] && cnt_r == $past(cnt_r);
    endproperty
    a_ovf: assert property (p_ovf) // R23
        else $error("overflow not flagged or entry lost");
    property p_pop;
        pop && !wr |=> cnt_r == $past(cnt_r) - 1;
    endproperty
    a_pop: assert property (p_pop) // R09
        else $error("queue count not decremented");
endmodule // scd_top

// *** test/scd_sw_model.sv ***
/*
 software side: drains the report queue in order when enabled.
 assumes: queue head settles one cycle after a pop.
*/
`timescale 1ns/1ps
module scd_sw_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // queue side
    input wire logic en_i,
    input wire logic empty_i,
    input wire logic [15:0] head_i,
    output logic pop_o,
    output logic [2:0] cnt_o
);
    logic [15:0] log_r [8];
    wire go = en_i && !empty_i && !pop_o;
    // read in order
    // every other cycle, so each head is seen settled
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pop_o <= 1'b0;
            cnt_o <= 3'h0;
        end
        else
        begin
            pop_o <= go;
            if (go)
                log_r[cnt_o] <= head_i;
            if (go)
                cnt_o <= cnt_o + 3'h1;
        end
    end
endmodule // scd_sw_model

// *** test/scd_top_tb_top.sv ***
/*
 bench for scd_top: summary rows, then stream, queue and error cases.
 assumes: epochs cut to 8 and 20 cycles and a four-entry queue.
*/
`timescale 1ns/1ps
module scd_top_tb_top;
    import scd_pkg::*;
    typedef struct packed {
        logic [3:1] pend;
        logic [3:0] srm;
        logic [3:1] perr;
        logic [4:0] isrm;
        logic [3:0] sr;
        logic [3:0] msr;
        logic irq;
    } scd_row_t;
    logic CLK_I, RESET_I, SLOT_VALID_I, SLOT_LOOPED_I, CFG_WE_I, FORCE_I;
    logic ERR_SRC_WE_I, FIFO_POP_I, FORCE_BUSY_O, FIFO_EMPTY_O, FIFO_FORCED_O;
    logic IRQ_O, en;
    logic [7:0] SLOT_NUM_I, CFG_SLOT_I, RD_SLOT_I, FORCE_SLOT_I, FIFO_SLOT_O;
    logic [7:0] ERR_SRC_WDATA_I, ERR_MASK_I, ERR_SRC_O;
    logic [6:0] RX_SIG_I, SRC_SIG_I, RD_RAW_O, RD_VLD_O, FIFO_SIG_O;
    logic [7:1] ERR_I;
    logic [3:1] PACK_PEND_I, PACK_ERR_I;
    logic [3:0] LINK_MUTE_I, SR_MASK_I, SR_O, MSR_O;
    logic [4:0] ISR_MASK_I, ISR_O;
    logic [2:0] cnt;
    logic [1:0] SLOT_LINK_I;
    scd_cfg_t CFG_SET_I, CFG_CLR_I, RD_CFG_O;
    int num_errors, checked, i;
    scd_row_t rows [5] = '{
        '{3'h5, 4'h3, 3'h0, 5'h00, 4'hA, 4'h2, 1'b1},
        '{3'h5, 4'h3, 3'h0, 5'h01, 4'hA, 4'h2, 1'b0},
        '{3'h0, 4'hF, 3'h2, 5'h08, 4'h0, 4'h0, 1'b0},
        '{3'h0, 4'hF, 3'h2, 5'h17, 4'h0, 4'h0, 1'b1},
        '{3'h7, 4'h0, 3'h0, 5'h00, 4'hE, 4'h0, 1'b0}};
    // arrival order: forced, slot, bits; the muted slot shows only as a forced report
    logic [15:0] exp_log [4] = '{{1'b0, 8'h01, 7'h55},
        {1'b0, 8'h01, 7'h0F}, {1'b0, 8'h03, 7'h71}, {1'b1, 8'h02, 7'h33}};

    wire [15:0] head = {FIFO_FORCED_O, FIFO_SLOT_O, FIFO_SIG_O};

    scd_top #(.FIFO_AW(2), .T3_CYC(8), .T10_CYC(20)) dut (
        .CLK_I(CLK_I), .RESET_I(RESET_I), .SLOT_VALID_I(SLOT_VALID_I),
        .SLOT_NUM_I(SLOT_NUM_I), .SLOT_LINK_I(SLOT_LINK_I),
        .SLOT_LOOPED_I(SLOT_LOOPED_I), .RX_SIG_I(RX_SIG_I),
        .SRC_SIG_I(SRC_SIG_I), .LINK_MUTE_I(LINK_MUTE_I),
        .CFG_WE_I(CFG_WE_I), .CFG_SLOT_I(CFG_SLOT_I), .CFG_SET_I(CFG_SET_I),
        .CFG_CLR_I(CFG_CLR_I), .RD_SLOT_I(RD_SLOT_I), .RD_RAW_O(RD_RAW_O),
        .RD_VLD_O(RD_VLD_O), .RD_CFG_O(RD_CFG_O), .FORCE_I(FORCE_I),
        .FORCE_SLOT_I(FORCE_SLOT_I), .FORCE_BUSY_O(FORCE_BUSY_O),
        .FIFO_POP_I(FIFO_POP_I), .FIFO_EMPTY_O(FIFO_EMPTY_O),
        .FIFO_FORCED_O(FIFO_FORCED_O), .FIFO_SLOT_O(FIFO_SLOT_O),
        .FIFO_SIG_O(FIFO_SIG_O), .PACK_PEND_I(PACK_PEND_I),
        .SR_MASK_I(SR_MASK_I), .SR_O(SR_O), .MSR_O(MSR_O), .ERR_I(ERR_I),
        .ERR_SRC_WE_I(ERR_SRC_WE_I), .ERR_SRC_WDATA_I(ERR_SRC_WDATA_I),
        .ERR_MASK_I(ERR_MASK_I), .ERR_SRC_O(ERR_SRC_O),
        .PACK_ERR_I(PACK_ERR_I), .ISR_MASK_I(ISR_MASK_I),
        .ISR_O(ISR_O), .IRQ_O(IRQ_O));
    scd_sw_model sw (.clk_i(CLK_I), .rst_i(RESET_I), .en_i(en),
        .empty_i(FIFO_EMPTY_O), .pop_o(FIFO_POP_I), .cnt_o(cnt),
        .head_i(head));

    initial
    begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    task automatic tick(int n = 1);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task automatic chk(string s, logic [17:0] got, logic [17:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", s, exp, got);
        end
    endtask
    function automatic scd_cfg_t mk(logic p, logic [6:0] g, logic [9:0] t);
        return {p, g, t};
    endfunction
    task automatic cfg(logic [7:0] s, scd_cfg_t st, scd_cfg_t cl);
        CFG_SLOT_I = s;
        CFG_SET_I = st;
        CFG_CLR_I = cl;
        CFG_WE_I = 1'b1;
        tick();
        CFG_WE_I = 1'b0;
    endtask
    // looped slots get inverted bits on the looped copy
    task automatic feed(logic [7:0] s, logic [1:0] l, logic [6:0] v,
        logic lp, int n);
        SLOT_NUM_I = s;
        SLOT_LINK_I = l;
        SLOT_LOOPED_I = lp;
        SRC_SIG_I = v;
        RX_SIG_I = lp ? ~v : v;
        SLOT_VALID_I = 1'b1;
        tick(n);
        SLOT_VALID_I = 1'b0;
        tick();
    endtask
    task automatic rd(logic [7:0] s);
        RD_SLOT_I = s;
        tick(2);
    endtask
    task automatic bound(int lim);
        if (i >= lim)
        begin
            num_errors++;
            $display("[FAIL] wait exp done got timeout");
            final_report();
        end
    endtask
    task automatic force_rep(logic [7:0] s);
        FORCE_SLOT_I = s;
        FORCE_I = 1'b1;
        tick();
        FORCE_I = 1'b0;
        chk("busy", FORCE_BUSY_O, 1'b1);
        for (i = 0; i < 20 && FORCE_BUSY_O !== 1'b0; i++)
            tick();
        bound(20);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        {SLOT_VALID_I, SLOT_LOOPED_I, CFG_WE_I, FORCE_I, en} = '0;
        {SLOT_NUM_I, CFG_SLOT_I, RD_SLOT_I, FORCE_SLOT_I} = '0;
        {ERR_SRC_WE_I, ERR_SRC_WDATA_I, ERR_MASK_I, ERR_I} = '0;
        {RX_SIG_I, SRC_SIG_I, PACK_PEND_I, PACK_ERR_I} = '0;
        {LINK_MUTE_I, SR_MASK_I, ISR_MASK_I, SLOT_LINK_I} = '0;
        {CFG_SET_I, CFG_CLR_I} = '0;
        num_errors = 0;
        checked = 0;
        RESET_I = 1'b1;
        tick(2);
        RESET_I = 1'b0;
        foreach (rows[k])
        begin
            PACK_PEND_I = rows[k].pend;
            SR_MASK_I = rows[k].srm;
            PACK_ERR_I = rows[k].perr;
            ISR_MASK_I = rows[k].isrm;
            tick();
            chk("sr", SR_O, rows[k].sr);
            chk("msr", MSR_O, rows[k].msr);
            chk("isr", ISR_O, {rows[k].perr, 1'b0, |rows[k].msr});
            chk("irq", IRQ_O, rows[k].irq);
        end
        {PACK_PEND_I, PACK_ERR_I, ISR_MASK_I} = '0;
        SR_MASK_I = 4'h1;
        $display("test summary rows done");
        rd(8'h03);
        chk("cfg rst", RD_CFG_O, mk(1'b0, 7'h7F, 10'h000));
        feed(8'h06, 2'h0, 7'h7F, 1'b0, 30);
        chk("empty", FIFO_EMPTY_O, 1'b1);
        $display("test reset done");
        cfg(8'h01, '0, mk(1'b0, 7'h7F, 10'h000));
        feed(8'h01, 2'h0, 7'h55, 1'b0, 30);
        rd(8'h01);
        chk("raw", RD_RAW_O, 7'h55);
        chk("vld", RD_VLD_O, 7'h55);
        chk("head", head, exp_log[0]);
        chk("sr0", SR_O[0], 1'b1);
        chk("irq own", IRQ_O, 1'b1);
        // short glitch must not validate
        feed(8'h01, 2'h0, 7'h00, 1'b0, 7);
        feed(8'h01, 2'h0, 7'h0F, 1'b1, 30);
        LINK_MUTE_I = 4'h2;
        cfg(8'h02, '0, mk(1'b0, 7'h7F, 10'h000));
        feed(8'h02, 2'h1, 7'h33, 1'b0, 30);
        rd(8'h02);
        chk("mute vld", RD_VLD_O, 7'h33);
        cfg(8'h03, mk(1'b0, 7'h70, 10'h000), mk(1'b0, 7'h0F, 10'h000));
        rd(8'h03);
        chk("cfg rmw", RD_CFG_O, mk(1'b0, 7'h70, 10'h000));
        feed(8'h03, 2'h0, 7'h70, 1'b0, 30);
        feed(8'h03, 2'h0, 7'h71, 1'b0, 30);
        $display("test stream done");
        force_rep(8'h02);
        force_rep(8'h01);
        tick();
        chk("ovf", ERR_SRC_O[0], 1'b1);
        chk("isr err", ISR_O[1], 1'b1);
        ERR_MASK_I = 8'h01;
        tick();
        chk("err mask", ISR_O[1], 1'b0);
        ERR_MASK_I = 8'hFF;
        ERR_I = 7'h04;
        tick();
        ERR_I = 7'h00;
        tick();
        chk("err src", ERR_SRC_O, 8'h09);
        ERR_SRC_WE_I = 1'b1;
        tick();
        ERR_SRC_WE_I = 1'b0;
        ERR_MASK_I = 8'h00;
        tick();
        chk("err src clr", ERR_SRC_O, 8'h00);
        en = 1'b1;
        for (i = 0; i < 40 && cnt !== 3'h4; i++)
            tick();
        bound(40);
        en = 1'b0;
        tick(2);
        foreach (exp_log[k])
            chk("log", sw.log_r[k], exp_log[k]);
        chk("sr0 clr", SR_O[0], 1'b0);
        $display("test queue done");
        cfg(8'h04, mk(1'b1, 7'h00, {5'h05, 5'h03}), mk(1'b0, 7'h7F, 10'h000));
        feed(8'h04, 2'h0, 7'h01, 1'b0, 15);
        chk("rise early", FIFO_EMPTY_O, 1'b1);
        feed(8'h04, 2'h0, 7'h01, 1'b0, 90);
        chk("rise", FIFO_SIG_O, 7'h01);
        en = 1'b1;
        tick(4);
        en = 1'b0;
        tick(2);
        feed(8'h04, 2'h0, 7'h00, 1'b0, 50);
        chk("fall early", FIFO_EMPTY_O, 1'b1);
        feed(8'h04, 2'h0, 7'h00, 1'b0, 120);
        chk("fall", FIFO_EMPTY_O, 1'b0);
        $display("test timed done");
        final_report();
    end
endmodule // scd_top_tb_top
